// [ssi_pkg.sv]
// Shared constants, register map and types of the serial position output
package ssi_pkg;

    // Reference clock rate
    localparam int CLK_MHZ = 25;

    // Position width (singleturn plus multiturn bits)
    localparam int POS_BITS = 25;

    // Depth of the raw sample buffer
    localparam int FIFO_DEPTH = 8;

    // Monoflop time in microseconds and its cycle count
    localparam int MONO_TIME_US = 20;
    localparam int MONO_CYCLES = MONO_TIME_US * CLK_MHZ;

    // Least hold time of the zero-set pulse (1.1 s) and its cycle count
    localparam int ZERO_HOLD_US = 1_100_000;
    localparam int ZERO_HOLD_CYCLES = ZERO_HOLD_US * CLK_MHZ;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_POSITION = 8'h08;
    localparam logic [7:0] REG_FROZEN = 8'h0C;
    localparam logic [7:0] REG_OFFSET = 8'h10;
    localparam logic [7:0] REG_COMMAND = 8'h14;

    // Control register layout: bit0 gray, bit1 run, bit2 special
    typedef struct packed {
        logic special;
        logic run;
        logic gray;
    } ctrl_s;

    localparam int CTRL_BITS = 3;
    localparam ctrl_s CTRL_RESET = 3'h2;

    // Status register field positions
    localparam int ST_STATE_LSB = 0;
    localparam int ST_RING_BIT = 2;
    localparam int ST_DIR_BIT = 3;
    localparam int ST_ZERO_BIT = 4;
    localparam int ST_SAMPLE_BIT = 5;

    // Command register field positions
    localparam int CMD_ZERO_BIT = 0;

    // Link states
    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_SHIFT = 2'b01,
        LINK_MONO = 2'b10
    } link_state_e;

endpackage : ssi_pkg

// [sync_filter.sv]
// Three-stage synchroniser with agreement filter for one outside input
`timescale 1ns/10ps
module sync_filter #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic pinIn,
    output logic level
);

    logic s1;
    logic s2;
    logic s3;

    // Chain; s1 feeds only s2 to keep metastability out of the logic
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1 <= RESET_VAL;
            s2 <= RESET_VAL;
            s3 <= RESET_VAL;
        end else begin
            s1 <= pinIn;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Level moves only once the last two stages agree
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            level <= RESET_VAL;
        end else if (s2 == s3) begin
            level <= s3;
        end
    end

endmodule : sync_filter

// [pos_fifo.sv]
// Small flip-flop FIFO for raw position samples
`timescale 1ns/10ps
module pos_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic push;
    logic pop;

    assign push = inValid & inReady;
    assign pop = outValid & outReady;
    assign outValid = (count != '0);
    assign outData = mem[rdPtr];

    // Occupancy after this cycle
    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // Count and registered ready, so the source sees a clean stall
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
            inReady <= 1'b1;
        end else begin
            count <= next_count;
            inReady <= (next_count != CW'(DEPTH));
        end
    end

    // Pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (push) begin
                wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            end
        end
    end

    // Storage carries no reset; contents are qualified by the count
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

endmodule : pos_fifo

// [ssi_absolute_position_output.sv]
// Synchronous serial position output of a multiturn absolute encoder
//
// Function
// RULE1 - Idle: master keeps clock high, encoder keeps data line high.
// RULE2 - First clock fall after idle freezes position word plus special bit.
// RULE3 - First rising clock edge presents the most significant bit.
// RULE4 - Each later rising edge presents the next lower bit down to LSB.
// RULE5 - After the LSB the data line goes low until monoflop timeout.
// RULE6 - Monoflop timeout starts at the final falling edge of a burst.
// RULE7 - Master waits for data high or its pause before a new transfer.
// RULE8 - Master keeps edge gaps inside a burst shorter than monoflop timeout.
// RULE9 - Word length equals total resolution; master clocks exactly that many bits. The code sends POS_BITS plus the special bit.
// RULE10 - Clocking on without pause repeats the same frozen word.
// RULE11 - Pulse n+1 after the timeout starts a fresh transfer with new sample.
// RULE12 - Master may compare repeated copies to catch transmission errors.
// RULE13 - Master lowers its clock rate on longer cables.
// RULE14 - A function input chooses the counting direction.
// RULE15 - Direction low or open counts up clockwise, high counts down.
// RULE16 - Zero-set falling edge held at least 1.1 s zeroes the position.
// RULE17 - Word is sent in Gray code or plain binary per configuration.
// RULE18 - Incoming clock is synchronised and edges found from the clean level.
`timescale 1ns/10ps
module ssi_absolute_position_output #(
    parameter int POS_BITS = ssi_pkg::POS_BITS,
    parameter int FIFO_DEPTH = ssi_pkg::FIFO_DEPTH,
    parameter int MONO_CYCLES = ssi_pkg::MONO_CYCLES,
    parameter int ZERO_HOLD_CYCLES = ssi_pkg::ZERO_HOLD_CYCLES
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    input wire logic sampleValid,
    input wire logic [POS_BITS-1:0] sampleData,
    output logic sampleReady,
    input wire logic sclkIn,
    output logic sdoOut,
    input wire logic dirIn,
    input wire logic zeroIn
);

    localparam int WORD_BITS = POS_BITS + 1;
    localparam int IDX_W = $clog2(WORD_BITS + 1);
    localparam int MONO_W = $clog2(MONO_CYCLES + 1);
    localparam int ZERO_W = $clog2(ZERO_HOLD_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////////

    // Control and link state
    ssi_pkg::ctrl_s ctrl;
    ssi_pkg::link_state_e state;

    // Filtered pins and link clock edges
    logic sclkLvl;
    logic sclkPrev;
    logic sclkFall;
    logic sclkRise;
    logic dirLvl;

    // Zero-set tracking, pin and software
    logic zeroLvl;
    logic zeroPrev;
    logic zeroArmed;
    logic [ZERO_W-1:0] zeroCnt;
    logic zeroFire;
    logic swZero;
    logic zeroSet;

    // Sample path from buffer to position
    logic fifoValid;
    logic [POS_BITS-1:0] fifoData;
    logic drain;
    logic [POS_BITS-1:0] rawLast;
    logic [POS_BITS-1:0] rawNow;
    logic [POS_BITS-1:0] adjLast;
    logic [POS_BITS-1:0] adjNow;
    logic [POS_BITS-1:0] offset;
    logic [POS_BITS-1:0] position;

    // Word being shifted, its timers and the register view
    logic [WORD_BITS-1:0] frozen;
    logic [IDX_W-1:0] bitIdx;
    logic [MONO_W-1:0] monoCnt;
    logic monoDone;
    logic ringActive;
    logic [31:0] statusWord;

    ////////////////////////////////////////////////////////////////////////////

    // Outside inputs, idle-high clock and zero-set, open direction reads low
    sync_filter #(.RESET_VAL(1'b1)) u_sync_clk (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .pinIn(sclkIn),
        .level(sclkLvl)
    );

    sync_filter #(.RESET_VAL(1'b0)) u_sync_dir (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .pinIn(dirIn),
        .level(dirLvl)
    );

    sync_filter #(.RESET_VAL(1'b1)) u_sync_zero (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .pinIn(zeroIn),
        .level(zeroLvl)
    );

    // Edge finder on the filtered clock level
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclkPrev <= 1'b1;
        end else begin
            sclkPrev <= sclkLvl; // RULE18
        end
    end

    assign sclkFall = sclkPrev & ~sclkLvl; // RULE18
    assign sclkRise = ~sclkPrev & sclkLvl; // RULE18

    ////////////////////////////////////////////////////////////////////////////

    // Raw samples buffered; software can pause the drain with the run bit
    pos_fifo #(.WIDTH(POS_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .inValid(sampleValid),
        .inReady(sampleReady),
        .inData(sampleData),
        .outValid(fifoValid),
        .outReady(ctrl.run),
        .outData(fifoData)
    );

    assign drain = fifoValid & ctrl.run;
    assign rawNow = drain ? fifoData : rawLast;

    // Direction applied by two's complement; a flip moves the zero point
    assign adjLast = dirLvl ? (~rawLast + 1'b1) : rawLast; // RULE14 RULE15
    assign adjNow = dirLvl ? (~rawNow + 1'b1) : rawNow; // RULE15
    assign position = adjLast - offset;

    // Latest raw sample
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rawLast <= '0;
        end else if (drain) begin
            rawLast <= fifoData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Zero-set: falling edge arms, firing only after the low has held long enough
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            zeroPrev <= 1'b1;
            zeroArmed <= 1'b0;
            zeroCnt <= '0;
        end else begin
            zeroPrev <= zeroLvl;
            if (zeroPrev && !zeroLvl) begin
                zeroArmed <= 1'b1; // RULE16
                zeroCnt <= '0;
            end else if (zeroLvl || zeroFire) begin
                zeroArmed <= 1'b0;
            end else if (zeroArmed) begin
                zeroCnt <= zeroCnt + 1'b1;
            end
        end
    end

    assign zeroFire = zeroArmed & ~zeroLvl & (zeroCnt == ZERO_W'(ZERO_HOLD_CYCLES - 1)); // RULE16
    assign swZero = regWrite & (regAddr == ssi_pkg::REG_COMMAND) & regWdata[ssi_pkg::CMD_ZERO_BIT];
    assign zeroSet = zeroFire | swZero;

    // Offset takes the newest adjusted value so the position reads zero
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            offset <= '0;
        end else if (zeroSet) begin
            offset <= adjNow; // RULE16
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Gray conversion of the position field
    function automatic logic [POS_BITS-1:0] toGray(input logic [POS_BITS-1:0] bin);
        return bin ^ (bin >> 1);
    endfunction : toGray

    assign monoDone = (monoCnt == MONO_W'(MONO_CYCLES - 1));

    // Link sequencer: idle, shifting a frozen word, monoflop wait
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ssi_pkg::LINK_IDLE;
            sdoOut <= 1'b1;
            frozen <= '0;
            bitIdx <= '0;
            monoCnt <= '0;
            ringActive <= 1'b0;
        end else begin
            case (state)
                ssi_pkg::LINK_IDLE: begin
                    sdoOut <= 1'b1; // RULE1
                    monoCnt <= '0;
                    ringActive <= 1'b0;
                    if (sclkFall) begin
                        frozen <= {ctrl.gray ? toGray(position) : position, ctrl.special}; // RULE2 RULE17 RULE11
                        bitIdx <= IDX_W'(WORD_BITS); // RULE9
                        state <= ssi_pkg::LINK_SHIFT;
                    end
                end
                ssi_pkg::LINK_SHIFT: begin
                    if (sclkRise && bitIdx != '0) begin
                        sdoOut <= frozen[bitIdx - 1'b1]; // RULE3 RULE4
                        bitIdx <= bitIdx - 1'b1; // RULE4
                        monoCnt <= '0;
                    end else if (sclkFall && bitIdx == '0) begin
                        sdoOut <= 1'b0; // RULE5
                        monoCnt <= '0; // RULE6
                        state <= ssi_pkg::LINK_MONO;
                    end else if (sclkFall) begin
                        monoCnt <= '0;
                    end else if (monoDone) begin
                        // Stalled master: give the line back rather than hang
                        sdoOut <= 1'b1;
                        state <= ssi_pkg::LINK_IDLE;
                    end else begin
                        monoCnt <= monoCnt + 1'b1;
                    end
                end
                ssi_pkg::LINK_MONO: begin
                    // Rises here belong to the separator pulse; its fall restarts the word
                    if (sclkFall) begin
                        bitIdx <= IDX_W'(WORD_BITS); // RULE10
                        monoCnt <= '0;
                        ringActive <= 1'b1;
                        state <= ssi_pkg::LINK_SHIFT;
                    end else if (monoDone) begin
                        sdoOut <= 1'b1; // RULE5 RULE11
                        state <= ssi_pkg::LINK_IDLE;
                    end else begin
                        sdoOut <= 1'b0; // RULE5
                        monoCnt <= monoCnt + 1'b1;
                    end
                end
                default: begin
                    sdoOut <= 1'b1;
                    state <= ssi_pkg::LINK_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Control register; code and special bit take effect at the next freeze
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= ssi_pkg::CTRL_RESET;
        end else if (regWrite && regAddr == ssi_pkg::REG_CTRL) begin
            ctrl <= ssi_pkg::ctrl_s'(regWdata[ssi_pkg::CTRL_BITS-1:0]); // RULE17
        end
    end

    // Status word assembled from live state
    always_comb begin
        statusWord = '0;
        statusWord[ssi_pkg::ST_STATE_LSB +: 2] = state;
        statusWord[ssi_pkg::ST_RING_BIT] = ringActive;
        statusWord[ssi_pkg::ST_DIR_BIT] = dirLvl;
        statusWord[ssi_pkg::ST_ZERO_BIT] = zeroLvl;
        statusWord[ssi_pkg::ST_SAMPLE_BIT] = fifoValid;
    end

    // Read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdata <= 32'h0000_0000;
        end else if (regRead) begin
            case (regAddr)
                ssi_pkg::REG_CTRL: regRdata <= 32'(ctrl);
                ssi_pkg::REG_STATUS: regRdata <= statusWord;
                ssi_pkg::REG_POSITION: regRdata <= 32'(position);
                ssi_pkg::REG_FROZEN: regRdata <= 32'(frozen);
                ssi_pkg::REG_OFFSET: regRdata <= 32'(offset);
                default: regRdata <= 32'h0000_0000;
            endcase
        end else begin
            regRdata <= 32'h0000_0000;
        end
    end

endmodule : ssi_absolute_position_output

// [ssi_output_props.sv]
// Concurrent checks on the serial position output ports
`timescale 1ns/10ps
module ssi_output_props #(
    parameter int MONO_CYCLES = 40
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [7:0] regAddr,
    input wire logic regRead,
    input wire logic [31:0] regRdata,
    input wire logic sampleValid,
    input wire logic sampleReady,
    input wire logic sclkIn,
    input wire logic sdoOut
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    logic [15:0] hiCnt;
    logic [15:0] quiet;
    logic [15:0] lowCnt;
    logic lastClk;
    ////////////////////////////////////////////////////////////////
    // Saturating run lengths, so a long idle cannot wrap to zero
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hiCnt <= 16'h0000;
            quiet <= 16'h0000;
            lowCnt <= 16'h0000;
            lastClk <= 1'h1;
        end else begin
            lastClk <= sclkIn;
            hiCnt <= !sclkIn ? 16'h0000 : hiCnt + {15'h0000, hiCnt != 16'hffff};
            quiet <= (sclkIn != lastClk) ? 16'h0000 : quiet + {15'h0000, quiet != 16'hffff};
            lowCnt <= sdoOut ? 16'h0000 : lowCnt + {15'h0000, lowCnt != 16'hffff};
        end
    end
    ////////////////////////////////////////////////////////////////
    // Idle long past the monoflop, then the opening clock fall
    sequence s_long_idle;
        hiCnt > MONO_CYCLES + 12;
    endsequence
    sequence s_start_fall;
        s_long_idle ##0 !sclkIn;
    endsequence
    a_idle_data_high: assert property (s_long_idle |-> sdoOut)
        else $error("data low while link idle");
    a_frame_start_high: assert property (s_start_fall |-> sdoOut [*6])
        else $error("data moved before first rise");
    a_fall_on_edge: assert property ($fell(sdoOut) |-> quiet < 8)
        else $error("data fell without clock edge");
    a_quiet_rises: assert property ($changed(sdoOut) && quiet > 8 |-> sdoOut)
        else $error("data fell on quiet clock");
    a_mono_length: assert property ($rose(sdoOut) && quiet > 8 |-> lowCnt >= MONO_CYCLES - 4)
        else $error("monoflop released early");
    a_rdata_after_read: assert property (regRdata != 32'h0000_0000 |-> $past(regRead))
        else $error("read data without read");
    a_unmapped_zero: assert property ($past(regRead) && $past(regAddr) > 8'h14 |-> regRdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_ready_drop: assert property ($fell(sampleReady) |-> $past(sampleValid))
        else $error("ready fell without sample");
endmodule : ssi_output_props

// [ssi_master_model.sv]
// Behavioural link master: clock bursts and word capture
`timescale 1ns/10ps
module ssi_master_model #(
    parameter int NBITS = 26
) (
    output logic sclk,
    input wire logic sdo
);
    logic [NBITS-1:0] word;
    event gotWord;
    ////////////////////////////////////////////////////////////////
    // Clock rests high between frames
    initial sclk = 1'h1;
    // Bits sampled late in the low phase, past the slave's synchroniser lag
    task automatic burst(input int words);
        for (int i = 0; i < 200 && sdo !== 1'h1; i++) #40;
        #7 sclk = 1'h0;
        #160;
        for (int w = 0; w < words; w++) begin
            // Pulse n+1 keeps the monoflop alive and restarts the frozen word
            if (w > 0) begin
                sclk = 1'h1;
                #160 sclk = 1'h0;
                #160;
            end
            for (int k = 0; k < NBITS; k++) begin
                sclk = 1'h1;
                #160 sclk = 1'h0;
                #115 word = {word[NBITS-2:0], sdo};
                #45;
            end
            ->gotWord;
        end
        sclk = 1'h1;
    endtask : burst
endmodule : ssi_master_model

// [test_ssi_absolute_position_output.sv]
// Self-checking bench for the serial position output
`timescale 1ns/10ps
module test_ssi_absolute_position_output;
    localparam int NB = ssi_pkg::POS_BITS;
    logic ref_clk = 1'h0;
    logic arst_n = 1'h0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0000_0000;
    logic regWrite = 1'h0;
    logic regRead = 1'h0;
    logic [31:0] regRdata;
    logic sampleValid = 1'h0;
    logic [NB-1:0] sampleData = '0;
    logic sampleReady;
    logic sclkIn;
    logic sdoOut;
    logic dirIn = 1'h0;
    logic zeroIn = 1'h1;
    logic rdSeen = 1'h0;
    logic [31:0] rng = 32'hc0c1_280f;
    logic [NB-1:0] raw = '0;
    logic [NB-1:0] off = '0;
    logic [31:0] rdQ[$];
    logic [NB:0] wQ[$];
    int n_fail = 0;
    int comparisons = 0;
    int got;
    ssi_absolute_position_output #(.MONO_CYCLES(40), .ZERO_HOLD_CYCLES(50)) ssi_absolute_position_output_inst (
        .ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .sampleValid(sampleValid), .sampleData(sampleData),
        .sampleReady(sampleReady), .sclkIn(sclkIn), .sdoOut(sdoOut), .dirIn(dirIn), .zeroIn(zeroIn)
    );
    ssi_master_model #(.NBITS(NB + 1)) ssi_master_model_inst (.sclk(sclkIn), .sdo(sdoOut));
    ////////////////////////////////////////////////////////////////
    always #20 ref_clk = ~ref_clk;
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs
    // Expected frame: adjusted, offset, optionally Gray, special bit last
    function automatic logic [NB:0] expWord(logic gray, logic dir, logic special);
        logic [NB-1:0] p;
        p = (dir ? -raw : raw) - off;
        return {gray ? p ^ (p >> 1) : p, special};
    endfunction : expWord
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regWrite <= 1'h1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWrite <= 1'h0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rdQ.push_back(e);
        regRead <= 1'h1;
        regAddr <= a;
        @(posedge ref_clk);
        regRead <= 1'h0;
        @(posedge ref_clk);
    endtask : rd
    task automatic push(input logic [NB-1:0] d);
        sampleValid <= 1'h1;
        sampleData <= d;
        for (int i = 0; i <= 20; i++) begin
            if (i == 20) begin
                n_fail++;
                conclude();
            end
            @(posedge ref_clk);
            if (sampleReady === 1'h1) break;
        end
        raw = d;
        sampleValid <= 1'h0;
        @(posedge ref_clk);
    endtask : push
    ////////////////////////////////////////////////////////////////
    // Read data stands only in the cycle after the strobe
    always @(posedge ref_clk) begin
        rdSeen <= regRead;
        if (rdSeen) check(regRdata, rdQ.pop_front());
    end
    // Each captured frame against the oldest expectation
    always @(ssi_master_model_inst.gotWord) check(ssi_master_model_inst.word, wQ.pop_front());
    initial begin
        #2_000_000;
        n_fail++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'h1;
        @(posedge ref_clk);
        check(sdoOut, 1'h1);
        rd(ssi_pkg::REG_CTRL, 32'h0000_0002);
        rd(8'h20, 32'h0000_0000);
        // Every code, direction and special setting; two copies per frame
        for (int m = 0; m < 8; m++) begin
            wr(ssi_pkg::REG_CTRL, {29'h0000_0000, m[2], 1'h1, m[0]});
            dirIn <= m[1];
            push(NB'(xs()));
            repeat (10) @(posedge ref_clk);
            rd(ssi_pkg::REG_POSITION, {7'h00, m[1] ? -raw : raw});
            repeat (2) wQ.push_back(expWord(m[0], m[1], m[2]));
            ssi_master_model_inst.burst(2);
            repeat (10) @(posedge ref_clk);
            check(sdoOut, 1'h0);
            repeat (50) @(posedge ref_clk);
            check(sdoOut, 1'h1);
        end
        // Buffer filled with draining stopped until it refuses
        wr(ssi_pkg::REG_CTRL, 32'h0000_0000);
        got = 0;
        sampleValid <= 1'h1;
        for (int i = 0; i < 12; i++) begin
            sampleData <= NB'(xs());
            @(posedge ref_clk);
            if (sampleReady === 1'h1) begin
                got++;
                raw = sampleData;
            end
        end
        sampleValid <= 1'h0;
        check(got, ssi_pkg::FIFO_DEPTH);
        check(sampleReady, 1'h0);
        rd(ssi_pkg::REG_STATUS, 32'h0000_0038);
        wr(ssi_pkg::REG_CTRL, 32'h0000_0002);
        repeat (12) @(posedge ref_clk);
        check(sampleReady, 1'h1);
        rd(ssi_pkg::REG_POSITION, {7'h00, -raw});
        // Short zero pulse is dropped, a long one zeroes the position
        zeroIn <= 1'h0;
        repeat (20) @(posedge ref_clk);
        zeroIn <= 1'h1;
        repeat (10) @(posedge ref_clk);
        rd(ssi_pkg::REG_POSITION, {7'h00, -raw});
        zeroIn <= 1'h0;
        repeat (70) @(posedge ref_clk);
        zeroIn <= 1'h1;
        repeat (10) @(posedge ref_clk);
        rd(ssi_pkg::REG_POSITION, 32'h0000_0000);
        off = -raw;
        push(NB'(xs()));
        repeat (10) @(posedge ref_clk);
        wQ.push_back(expWord(1'h0, 1'h1, 1'h0));
        ssi_master_model_inst.burst(1);
        repeat (60) @(posedge ref_clk);
        // Frozen word and offset readable; software zero acts like the pin
        rd(ssi_pkg::REG_FROZEN, {6'h00, expWord(1'h0, 1'h1, 1'h0)});
        rd(ssi_pkg::REG_OFFSET, {7'h00, off});
        wr(ssi_pkg::REG_COMMAND, 32'h0000_0001);
        rd(ssi_pkg::REG_POSITION, 32'h0000_0000);
        repeat (2) @(posedge ref_clk);
        conclude();
    end
endmodule : test_ssi_absolute_position_output
bind ssi_absolute_position_output ssi_output_props #(.MONO_CYCLES(MONO_CYCLES)) props_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr), .regRead(regRead), .regRdata(regRdata),
    .sampleValid(sampleValid), .sampleReady(sampleReady), .sclkIn(sclkIn), .sdoOut(sdoOut)
);
